//--- src/port_e_regs.svh
// Purpose: offsets, reset values and widths of the port e register set
// Assumes: 16-bit registers, word index addressing on the plain register port
// Notes: included by its bare name
`ifndef PORT_E_REGS_SVH
`define PORT_E_REGS_SVH

`define PORT_WIDTH 16
`define ADDR_WIDTH 4
`define NUM_OUT_FUNCS 4
`define FSEL_WIDTH 3

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFF_DIRECTION 4'h0
`define OFF_PIN_LEVEL 4'h1
`define OFF_OUTPUT_LATCH 4'h2
`define OFF_OPEN_DRAIN 4'h3
`define OFF_CHANGE_NOTIFY 4'h4
`define OFF_PULL_UP 4'h5
`define OFF_PULL_DOWN 4'h6
`define OFF_ANALOG_SELECT 4'h7
`define OFF_OUT_MAP_LO 4'h8
`define OFF_OUT_MAP_HI 4'h9
`define OFF_CHANGE_STATUS 4'ha

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_DIRECTION 16'hffff
`define RST_ZERO 16'h0000
`define ANALOG_CAPABLE 16'h0000
`define RST_ANALOG_SELECT `ANALOG_CAPABLE

`endif

//--- src/port_e_pkg.sv
// Purpose: types shared by the port e pin mapping logic
// Assumes: constants come from port_e_regs.svh
// Notes: none
`include "port_e_regs.svh"

package port_e_pkg;
  typedef logic [`PORT_WIDTH-1:0] port_word_type;
  // per-pin remappable output selection: 0 none, 1..4 function index
  typedef logic [`FSEL_WIDTH-1:0] func_sel_type;
endpackage

//--- src/pin_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for one pin group
// Assumes: inputs asynchronous to core_clk_in
// Notes: first stage is read only by the second
`timescale 1ns/1ps

module pin_sync3 #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_state_type;

  sync_state_type st_q;
  sync_state_type st_d;

  // shift chain; level moves only where stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 | st_q.s3));
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule // pin_sync3

//--- src/pin_function_mapping_port.sv
// Purpose: port e control registers and per-pin output/input arbitration
// Assumes: dedicated peripherals present enables and data per pin
// Notes: remappable outputs are routed by per-pin selection registers on pins 0 to 7 only
//
// Overview of operation
// - each pin is driven by at most one output function at a time
// - one remappable output may be routed to several pins together
// - dedicated output beats any remappable output on the same pin
// - pins with dedicated digital function still feed remappable inputs
// - analog selection disables every digital input path of the pin
// - analog pins may still drive one digital output
// - any number of remappable inputs may watch the same pin
// - direction bits govern only the general-purpose output buffer
// - active peripheral outputs drive the pin whatever direction says
// - direction bits never touch the digital input buffer
// - analog-capable pins come up analog after every reset
// - digital input buffer is held off while analog is selected
// - only analog-select bits gate the digital input buffer
// - unimplemented analog-select bits and unmapped words read back as zero
`timescale 1ns/1ps
`include "port_e_regs.svh"

module pin_function_mapping_port
  import port_e_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [`ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic [`PORT_WIDTH-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [`PORT_WIDTH-1:0] reg_rdata_out,
  // dedicated peripheral functions, one bit per pin
  input wire logic [`PORT_WIDTH-1:0] ded_out_en_in,
  input wire logic [`PORT_WIDTH-1:0] ded_out_data_in,
  // remappable output function sources
  input wire logic [`NUM_OUT_FUNCS-1:0] remap_out_data_in,
  // pins
  input wire logic [`PORT_WIDTH-1:0] pin_in,
  output logic [`PORT_WIDTH-1:0] pin_out,
  output logic [`PORT_WIDTH-1:0] pin_oe_out,
  output logic [`PORT_WIDTH-1:0] pull_up_out,
  output logic [`PORT_WIDTH-1:0] pull_down_out,
  // digital input seen by remappable and dedicated inputs
  output logic [`PORT_WIDTH-1:0] pin_digital_out,
  output logic change_notify_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    port_word_type dir;
    port_word_type latch;
    port_word_type odc;
    port_word_type cn_en;
    port_word_type pu;
    port_word_type pd;
    port_word_type ansel;
    logic [2*`PORT_WIDTH*2-1:0] map_raw;
    port_word_type cn_stat;
    port_word_type prev_in;
    port_word_type rdata;
    port_word_type pin_o;
    port_word_type pin_oe;
    port_word_type pu_o;
    port_word_type pd_o;
    port_word_type dig;
    logic cn_o;
  } port_state_type;

  port_state_type st_q;
  port_state_type st_d;
  port_word_type pin_sync;

  // pins are asynchronous: three stages with agreement before use
  pin_sync3 #(
    .WIDTH(`PORT_WIDTH)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(pin_in),
    .level_out(pin_sync)
  );

  // per-pin remappable selection: four bits per pin over two words
  function automatic func_sel_type pin_sel(input logic [2*`PORT_WIDTH*2-1:0] raw,
                                           input int idx);
    logic [3:0] nib;
    nib = raw[idx*4 +: 4];
    pin_sel = nib[`FSEL_WIDTH-1:0];
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    func_sel_type sel;
    port_word_type dig_in;
    port_word_type changed;
    st_d = st_q;
    sel = '0;
    dig_in = '0;
    changed = '0;

    // register writes; analog bits exist only on analog-capable pins
    if (reg_write_in) begin
      case (reg_addr_in)
        `OFF_DIRECTION: st_d.dir = reg_wdata_in;
        `OFF_OUTPUT_LATCH: st_d.latch = reg_wdata_in;
        `OFF_PIN_LEVEL: st_d.latch = reg_wdata_in; // writes land in the latch
        `OFF_OPEN_DRAIN: st_d.odc = reg_wdata_in;
        `OFF_CHANGE_NOTIFY: st_d.cn_en = reg_wdata_in;
        `OFF_PULL_UP: st_d.pu = reg_wdata_in;
        `OFF_PULL_DOWN: st_d.pd = reg_wdata_in;
        `OFF_ANALOG_SELECT: st_d.ansel = reg_wdata_in & `ANALOG_CAPABLE;
        `OFF_OUT_MAP_LO: st_d.map_raw[`PORT_WIDTH-1:0] = reg_wdata_in;
        `OFF_OUT_MAP_HI: st_d.map_raw[2*`PORT_WIDTH-1:`PORT_WIDTH] = reg_wdata_in;
        default: ;
      endcase
    end

    // digital input buffer gated by analog select alone, never direction
    dig_in = pin_sync & ~st_q.ansel;
    // same word fans out to every remappable and dedicated input
    st_d.dig = dig_in;

    // change notification: set wins over a clearing write
    changed = (dig_in ^ st_q.prev_in) & st_q.cn_en;
    st_d.prev_in = dig_in;
    if (reg_write_in && reg_addr_in == `OFF_CHANGE_STATUS) begin
      st_d.cn_stat = st_q.cn_stat & ~reg_wdata_in;
    end
    st_d.cn_stat = st_d.cn_stat | changed;
    st_d.cn_o = |st_d.cn_stat;

    // output arbitration per pin: one driver, dedicated first
    for (int i = 0; i < `PORT_WIDTH; i++) begin
      sel = (i < 8) ? pin_sel(st_q.map_raw, i) : '0;
      if (ded_out_en_in[i]) begin
        st_d.pin_o[i] = ded_out_data_in[i];
        st_d.pin_oe[i] = 1'b1;
      end else if (sel != '0 && sel <= `NUM_OUT_FUNCS) begin
        st_d.pin_o[i] = remap_out_data_in[sel-1];
        st_d.pin_oe[i] = 1'b1;
      end else begin
        st_d.pin_o[i] = st_q.latch[i];
        st_d.pin_oe[i] = ~st_q.dir[i];
      end
      // open drain: release instead of driving high
      if (st_q.odc[i] && st_d.pin_o[i]) begin
        st_d.pin_oe[i] = 1'b0;
      end
    end
    st_d.pu_o = st_q.pu;
    st_d.pd_o = st_q.pd;

    // read data one cycle after the strobe, zero otherwise
    st_d.rdata = '0;
    if (reg_read_in) begin
      case (reg_addr_in)
        `OFF_DIRECTION: st_d.rdata = st_q.dir;
        `OFF_PIN_LEVEL: st_d.rdata = dig_in;
        `OFF_OUTPUT_LATCH: st_d.rdata = st_q.latch;
        `OFF_OPEN_DRAIN: st_d.rdata = st_q.odc;
        `OFF_CHANGE_NOTIFY: st_d.rdata = st_q.cn_en;
        `OFF_PULL_UP: st_d.rdata = st_q.pu;
        `OFF_PULL_DOWN: st_d.rdata = st_q.pd;
        `OFF_ANALOG_SELECT: st_d.rdata = st_q.ansel & `ANALOG_CAPABLE;
        `OFF_OUT_MAP_LO: st_d.rdata = st_q.map_raw[`PORT_WIDTH-1:0];
        `OFF_OUT_MAP_HI: st_d.rdata = st_q.map_raw[2*`PORT_WIDTH-1:`PORT_WIDTH];
        `OFF_CHANGE_STATUS: st_d.rdata = st_q.cn_stat;
        default: st_d.rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.dir <= `RST_DIRECTION;
      st_q.ansel <= `RST_ANALOG_SELECT;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = st_q.rdata;
  assign pin_out = st_q.pin_o;
  assign pin_oe_out = st_q.pin_oe;
  assign pull_up_out = st_q.pu_o;
  assign pull_down_out = st_q.pd_o;
  assign pin_digital_out = st_q.dig;
  assign change_notify_out = st_q.cn_o;
endmodule // pin_function_mapping_port

//--- verif/port_map_checker.sv
// Purpose: timing checks on the port e block, seen at its ports
// Assumes: one clock, synchronous active-high reset
// Notes: pin margin covers synchroniser, filter and register
`timescale 1ns/1ps
`include "port_e_regs.svh"
module port_map_checker
  import port_e_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [`ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire port_word_type reg_rdata_out,
  input wire port_word_type ded_out_en_in,
  input wire port_word_type ded_out_data_in,
  input wire port_word_type pin_in,
  input wire port_word_type pin_out,
  input wire port_word_type pin_oe_out,
  input wire port_word_type pin_digital_out,
  input wire logic change_notify_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  port_word_type ded_low;
  // pins a dedicated function pulls low
  assign ded_low = ded_out_en_in & ~ded_out_data_in;
  // pins held long enough to cross the input filter
  sequence pins_quiet;
    $stable(pin_in) [*7];
  endsequence
  reset_state_a: assert property ($fell(rst_in) |->
    pin_oe_out == 16'h0000 && !change_notify_out) else $error("outputs busy after reset");
  rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == 16'h0000)
    else $error("read data outside answer cycle");
  analog_zero_a: assert property (reg_read_in && reg_addr_in == `OFF_ANALOG_SELECT |=>
    reg_rdata_out == 16'h0000) else $error("analog select bits not zero");
  unmapped_zero_a: assert property (reg_read_in && reg_addr_in > `OFF_CHANGE_STATUS |=>
    reg_rdata_out == 16'h0000) else $error("unmapped word not zero");
  ded_low_a: assert property (|ded_low |=>
    (pin_oe_out & ~pin_out & $past(ded_low)) == $past(ded_low)) else $error("dedicated lost");
  input_follow_a: assert property (pins_quiet |-> pin_digital_out == pin_in)
    else $error("digital input not following pin");
  level_read_a: assert property (pins_quiet ##0 reg_read_in &&
    reg_addr_in == `OFF_PIN_LEVEL |=> reg_rdata_out == $past(pin_in)) else $error("pin level");
  input_untouched_a: assert property (pins_quiet ##0 reg_write_in |=>
    pin_digital_out == $past(pin_in)) else $error("write disturbed input");
endmodule // port_map_checker

bind pin_function_mapping_port port_map_checker port_map_checker_i (.core_clk_in, .rst_in,
  .reg_addr_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .ded_out_en_in, .ded_out_data_in,
  .pin_in, .pin_out, .pin_oe_out, .pin_digital_out, .change_notify_out);

//--- verif/pin_board_model.sv
// Purpose: board side of the port e pins
// Assumes: an external source holds every pin the block releases
// Notes: no contention model, the block drive wins
`timescale 1ns/1ps
module pin_board_model
  import port_e_pkg::*;
(
  input wire port_word_type drive_in,
  input wire port_word_type drive_en_in,
  input wire port_word_type ext_val_in,
  output port_word_type level_out
);
  // released pins show the external level, never a stale drive
  assign level_out = (drive_en_in & drive_in) | (~drive_en_in & ext_val_in);
endmodule // pin_board_model

//--- verif/pin_function_mapping_port_bench.sv
// Purpose: self-checking bench for the port e pin mapping block
// Assumes: board model loops driven pins back into pin_in
// Notes: random mixes of direction, maps and dedicated enables
`timescale 1ns/1ps
`include "port_e_regs.svh"
module pin_function_mapping_port_bench
  import port_e_pkg::*;;
  logic core_clk_in = 1'b0, rst_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic [`ADDR_WIDTH-1:0] reg_addr_in = 4'h0, rw_regs [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
  logic [`NUM_OUT_FUNCS-1:0] remap_out_data_in = 4'h0;
  port_word_type reg_wdata_in = 16'h0000, ded_out_en_in = 16'h0000, ded_out_data_in = 16'h0000;
  port_word_type ext_val = 16'h0000, v, dir, lat, reg_rdata_out, pin_in, pin_out, pin_oe_out;
  port_word_type pull_up_out, pull_down_out, pin_digital_out;
  logic change_notify_out;
  logic [31:0] map, e;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  pin_function_mapping_port pin_function_mapping_port_i (.core_clk_in, .rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .ded_out_en_in, .ded_out_data_in,
    .remap_out_data_in, .pin_in, .pin_out, .pin_oe_out, .pull_up_out, .pull_down_out,
    .pin_digital_out, .change_notify_out);
  pin_board_model pin_board_model_i (.drive_in(pin_out), .drive_en_in(pin_oe_out),
    .ext_val_in(ext_val), .level_out(pin_in));
  // 125 MHz clock
  initial forever #4 core_clk_in = ~core_clk_in;
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input port_word_type got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus cycle; a read compares the answer in its single valid cycle
  task automatic bus(input logic wr, input logic [`ADDR_WIDTH-1:0] a, input port_word_type d);
    @(posedge core_clk_in);
    reg_write_in <= wr;
    reg_read_in <= !wr;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
    reg_read_in <= 1'b0;
    #1;
    if (!wr) chk(reg_rdata_out, d);
  endtask
  // priority: dedicated, then remapped function, then latch under direction
  function automatic logic [31:0] expect_pins(input port_word_type dir, lat, den, dd,
    input logic [31:0] map, input logic [`NUM_OUT_FUNCS-1:0] rf);
    logic [31:0] r;
    logic [2:0] s;
    r = {~dir, lat};
    for (int k = 0; k < 16; k++) begin
      s = k < 8 ? map[4*k+:3] : 3'h0;
      // selections above the last function index route nothing
      if (s != 3'h0 && s <= 3'h4) r[16+k] = 1'b1;
      if (s != 3'h0 && s <= 3'h4) r[k] = rf[s-3'h1];
      if (den[k]) r[16+k] = 1'b1;
      if (den[k]) r[k] = dd[k];
    end
    return r;
  endfunction
  initial begin
    void'($urandom(62));
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    // reset values, read-back, read-only and unmapped words
    for (int a = 0; a < 8; a++) bus(1'b0, a[3:0], a == 0 ? 16'hffff : 16'h0000);
    repeat (3) foreach (rw_regs[i]) begin
      v = $urandom;
      bus(1'b1, rw_regs[i], v);
      bus(1'b0, rw_regs[i], v);
      if (rw_regs[i] == `OFF_PULL_UP) chk(pull_up_out, v);
      if (rw_regs[i] == `OFF_PULL_DOWN) chk(pull_down_out, v);
    end
    bus(1'b1, `OFF_ANALOG_SELECT, 16'hffff);
    bus(1'b0, `OFF_ANALOG_SELECT, 16'h0000);
    bus(1'b0, 4'hc, 16'h0000);
    for (int k = 3; k < 7; k++) bus(1'b1, k[3:0], 16'h0000);
    // first pass routes function one to all eight mapped pins
    for (int i = 0; i < 24; i++) begin
      dir = $urandom;
      lat = $urandom;
      map = 32'h1111_1111;
      if (i > 0) for (int k = 0; k < 8; k++) map[4*k+:4] = 4'($urandom_range(7, 0));
      bus(1'b1, `OFF_DIRECTION, dir);
      bus(1'b1, `OFF_OUTPUT_LATCH, lat);
      bus(1'b1, `OFF_OUT_MAP_LO, map[15:0]);
      bus(1'b1, `OFF_OUT_MAP_HI, map[31:16]);
      ded_out_en_in <= i == 0 ? 16'h0000 : 16'($urandom);
      ded_out_data_in <= $urandom;
      remap_out_data_in <= $urandom;
      ext_val <= $urandom;
      repeat (2) @(posedge core_clk_in);
      #1;
      e = expect_pins(dir, lat, ded_out_en_in, ded_out_data_in, map, remap_out_data_in);
      chk(pin_oe_out, e[31:16]);
      chk(pin_out & e[31:16], e[15:0] & e[31:16]);
      v = (e[31:16] & e[15:0]) | (~e[31:16] & ext_val);
      repeat (8) @(posedge core_clk_in);
      #1;
      chk(pin_digital_out, v);
      bus(1'b0, `OFF_PIN_LEVEL, v);
    end
    // general outputs only, then open drain releases the high bits
    ded_out_en_in <= 16'h0000;
    bus(1'b1, `OFF_OUT_MAP_LO, 16'h0000);
    bus(1'b1, `OFF_OUT_MAP_HI, 16'h0000);
    bus(1'b1, `OFF_DIRECTION, 16'h0000);
    bus(1'b1, `OFF_PIN_LEVEL, lat);
    bus(1'b0, `OFF_OUTPUT_LATCH, lat);
    bus(1'b1, `OFF_OPEN_DRAIN, 16'hffff);
    @(posedge core_clk_in);
    #1;
    chk(pin_oe_out, ~lat);
    // inputs only, one pin watched for a change
    bus(1'b1, `OFF_DIRECTION, 16'hffff);
    bus(1'b1, `OFF_OPEN_DRAIN, 16'h0000);
    bus(1'b1, `OFF_CHANGE_NOTIFY, 16'h0001);
    ext_val <= 16'h0000;
    repeat (10) @(posedge core_clk_in);
    bus(1'b1, `OFF_CHANGE_STATUS, 16'hffff);
    bus(1'b0, `OFF_CHANGE_STATUS, 16'h0000);
    ext_val <= 16'h8001;
    repeat (10) @(posedge core_clk_in);
    bus(1'b0, `OFF_CHANGE_STATUS, 16'h0001);
    chk({15'h0000, change_notify_out}, 16'h0001);
    bus(1'b1, `OFF_CHANGE_STATUS, 16'h0001);
    @(posedge core_clk_in);
    #1;
    chk({15'h0000, change_notify_out}, 16'h0000);
    conclude();
  end
endmodule // pin_function_mapping_port_bench
